// ==== core/mus_pkg.sv ====
// Constants, field layout and helper functions of the user stream block
package mus_pkg;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int E_WORD_LSB = 0;
  localparam int E_MASK_LSB = 64;
  localparam int E_EOF = 72;
  localparam int E_SOF = 73;
  localparam int E_GOOD = 74;
  localparam int ENTRY_W = 75;
  localparam int USER_CLK_MHZ = 100;
  localparam int RX_OUTBUF_DEPTH_BITS = 10;
  localparam logic [4:0] PHY_MGMT_DEVICE_ADDR = 5'h00;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
  localparam logic [63:0] PREAMBLE_WORD = 64'hD555_5555_5555_55FB;
  localparam logic [14:0] MIN_FILL = 15'h003C;
  localparam logic [14:0] MIN_FRAME = 15'h0040;
  localparam logic [14:0] RX_PAYLOAD_LIMIT = 15'h05DC;
  localparam logic [14:0] HDR_FCS_BYTES = 15'h0012;

  typedef enum logic [2:0] {TX_IDLE, TX_BODY, TX_PAD, TX_TAIL} mus_tx_state_t;

  // Number of meaningful bytes in a contiguous mask
  function automatic logic [3:0] mus_byte_count(logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, m[i]};
    end
    return n;
  endfunction

  // Contiguous mask of n low lanes, n from 0 to 8
  function automatic logic [7:0] mus_bytes_mask(logic [3:0] n);
    return 8'hFF >> (4'h8 - n);
  endfunction

  // Reflected CRC-32 over the n low bytes of a word, byte 0 first
  function automatic logic [31:0] mus_crc_step(logic [31:0] c, logic [63:0] d,
                                               logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        for (int b = 0; b < 8; b++) begin
          r = (r[0] ^ d[8 * i + b]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
      end
    end
    return r;
  endfunction
endpackage

// ==== core/mus_stream_if.sv ====
// Valid/ready word carrier between the block's own modules
`timescale 1ns/1ps
interface mus_stream_if;
  import mus_pkg::*;
  logic [ENTRY_W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== core/mus_pair_buffer.sv ====
// Two-entry elastic buffer with valid/ready on both sides
`timescale 1ns/1ps
module mus_pair_buffer
  import mus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  mus_stream_if.snk inPort,
  mus_stream_if.src outPort,
  output logic [1:0] count
);
  logic [ENTRY_W-1:0] mem [2];
  logic wrPtr;
  logic rdPtr;
  logic doWrite;
  logic doRead;

  assign inPort.ready = (count != 2'd2);
  assign outPort.valid = (count != 2'd0);
  assign outPort.data = mem[rdPtr];
  assign doWrite = inPort.valid && inPort.ready;
  assign doRead = outPort.valid && outPort.ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end else if (clear) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end else begin
      wrPtr <= wrPtr ^ doWrite;
      rdPtr <= rdPtr ^ doRead;
      count <= count + {1'b0, doWrite} - {1'b0, doRead};
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inPort.data;
    end
  end
endmodule

// ==== core/mus_user_stream.sv ====
// User-side transmit and receive stream paths of the 10G MAC
`timescale 1ns/1ps
module mus_user_stream (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic syncReset,
  input wire logic padEnable,
  input wire logic crcEnable,
  input wire logic [mus_pkg::DATA_W-1:0] txUserWord,
  input wire logic [mus_pkg::MASK_W-1:0] txByteMask,
  input wire logic txFirstWordPulse,
  input wire logic txLastWordPulse,
  output logic txAcceptReady,
  output logic [mus_pkg::DATA_W-1:0] rxUserWord,
  output logic [mus_pkg::MASK_W-1:0] rxByteMask,
  output logic rxFirstWordPulse,
  output logic rxLastWordPulse,
  output logic rxFrameGood,
  input wire logic rxSinkReady,
  output logic [mus_pkg::DATA_W-1:0] lineTxWord,
  output logic [mus_pkg::MASK_W-1:0] lineTxMask,
  output logic lineTxValid,
  output logic lineTxStart,
  output logic lineTxEnd,
  input wire logic [mus_pkg::DATA_W-1:0] lineRxWord,
  input wire logic [mus_pkg::MASK_W-1:0] lineRxMask,
  input wire logic lineRxValid,
  input wire logic lineRxStart,
  input wire logic lineRxEnd,
  output logic [4:0] phyMgmtDeviceAddr
);
  import mus_pkg::*;

  // ************************************************************
  // Elastic buffers
  // ************************************************************
  mus_stream_if txIn();
  mus_stream_if txOut();
  mus_stream_if rxIn();
  mus_stream_if rxOut();
  logic [1:0] txCount;
  logic [1:0] rxCount;

  mus_pair_buffer txBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(syncReset),
    .inPort(txIn),
    .outPort(txOut),
    .count(txCount)
  );

  mus_pair_buffer rxBuf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(syncReset),
    .inPort(rxIn),
    .outPort(rxOut),
    .count(rxCount)
  );

  // ************************************************************
  // Transmit intake
  // ************************************************************
  logic txPush;
  logic txPop;
  logic [2:0] txNextCount;

  // Mask 00 with no marker carries nothing and is not stored
  assign txPush = (|txByteMask) | txFirstWordPulse | txLastWordPulse;
  assign txIn.valid = txPush;
  assign txIn.data = {1'b0, txFirstWordPulse, txLastWordPulse, txByteMask, txUserWord};
  assign txOut.ready = txPop;
  assign txNextCount = {1'b0, txCount} + {2'b00, txIn.valid && txIn.ready}
                       - {2'b00, txPop && txOut.valid};

  // ************************************************************
  // Transmit framer
  // ************************************************************
  mus_tx_state_t txState;
  mus_tx_state_t next_txState;
  logic [14:0] txBytes;
  logic [14:0] next_txBytes;
  logic [31:0] txCrc;
  logic [31:0] next_txCrc;
  logic [31:0] txOver;
  logic [31:0] next_txOver;
  logic [7:0] txOverMask;
  logic [7:0] next_txOverMask;
  logic [63:0] next_lineTxWord;
  logic [7:0] next_lineTxMask;
  logic next_lineTxValid;
  logic next_lineTxStart;
  logic next_lineTxEnd;

  logic [63:0] hWord;
  logic [7:0] hMask;
  logic hEof;
  logic hSof;
  logic [3:0] hN;
  logic [14:0] padLeft;
  logic [3:0] padN;
  logic inPad;
  logic [3:0] curN;
  logic [7:0] curMask;
  logic [63:0] curRaw;
  logic [63:0] curWord;
  logic [14:0] curTotal;
  logic [31:0] curCrc;
  logic [95:0] merged;
  logic [3:0] mergedN;
  logic needPad;
  logic finishing;

  assign hWord = txOut.data[E_WORD_LSB +: DATA_W];
  assign hMask = txOut.data[E_MASK_LSB +: MASK_W];
  assign hEof = txOut.data[E_EOF];
  assign hSof = txOut.data[E_SOF];
  assign hN = mus_byte_count(hMask);
  assign padLeft = MIN_FILL - txBytes;
  assign padN = (padLeft >= 15'd8) ? 4'd8 : padLeft[3:0];
  assign inPad = (txState == TX_PAD);
  assign curN = inPad ? padN : hN;
  assign curMask = mus_bytes_mask(curN);
  assign curRaw = inPad ? 64'h0000_0000_0000_0000 : hWord;

  // Unused lanes are zeroed so the appended FCS can be OR-merged
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : laneZero
      assign curWord[8 * gi +: 8] = curRaw[8 * gi +: 8] & {8{curMask[gi]}};
    end
  endgenerate

  assign curTotal = txBytes + {11'h000, curN};
  assign curCrc = mus_crc_step(txCrc, curWord, curN);
  assign merged = {32'h0000_0000, curWord} | ({64'h0, ~curCrc} << {curN, 3'b000});
  assign mergedN = curN + 4'd4;
  assign needPad = padEnable && crcEnable && (curTotal < MIN_FILL);
  assign finishing = inPad ? (curTotal >= MIN_FILL) : (hEof && !needPad);

  always_comb begin
    next_txState = txState;
    next_txBytes = txBytes;
    next_txCrc = txCrc;
    next_txOver = txOver;
    next_txOverMask = txOverMask;
    next_lineTxWord = 64'h0000_0000_0000_0000;
    next_lineTxMask = 8'h00;
    next_lineTxValid = 1'b0;
    next_lineTxStart = 1'b0;
    next_lineTxEnd = 1'b0;
    txPop = 1'b0;
    case (txState)
      TX_IDLE: begin
        if (txOut.valid && hSof) begin
          // Preamble and start delimiter go out before the first word
          next_lineTxWord = PREAMBLE_WORD;
          next_lineTxMask = 8'hFF;
          next_lineTxValid = 1'b1;
          next_lineTxStart = 1'b1;
          next_txBytes = 15'h0000;
          next_txCrc = CRC_INIT;
          next_txState = TX_BODY;
        end else if (txOut.valid) begin
          // A word outside a frame has no home and is discarded
          txPop = 1'b1;
        end
      end
      TX_BODY, TX_PAD: begin
        if (inPad || txOut.valid) begin
          txPop = !inPad;
          next_txBytes = curTotal;
          next_txCrc = curCrc;
          next_lineTxValid = 1'b1;
          next_lineTxWord = curWord;
          next_lineTxMask = curMask;
          if (!inPad && hEof && needPad) begin
            next_txState = TX_PAD;
          end else if (finishing && crcEnable) begin
            next_lineTxWord = merged[63:0];
            next_lineTxMask = mus_bytes_mask((mergedN > 4'd8) ? 4'd8 : mergedN);
            next_txOver = merged[95:64];
            next_txOverMask = (mergedN > 4'd8) ? mus_bytes_mask(mergedN - 4'd8) : 8'h00;
            next_lineTxEnd = (mergedN <= 4'd8);
            next_txState = (mergedN > 4'd8) ? TX_TAIL : TX_IDLE;
          end else if (finishing) begin
            next_lineTxEnd = 1'b1;
            next_txState = TX_IDLE;
          end
        end
      end
      TX_TAIL: begin
        next_lineTxWord = {32'h0000_0000, txOver};
        next_lineTxMask = txOverMask;
        next_lineTxValid = 1'b1;
        next_lineTxEnd = 1'b1;
        next_txState = TX_IDLE;
      end
      default: begin
        next_txState = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      txBytes <= 15'h0000;
      txCrc <= CRC_INIT;
      txOver <= 32'h0000_0000;
      txOverMask <= 8'h00;
    end else if (syncReset) begin
      txState <= TX_IDLE;
      txBytes <= 15'h0000;
      txCrc <= CRC_INIT;
      txOver <= 32'h0000_0000;
      txOverMask <= 8'h00;
    end else begin
      txState <= next_txState;
      txBytes <= next_txBytes;
      txCrc <= next_txCrc;
      txOver <= next_txOver;
      txOverMask <= next_txOverMask;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineTxWord <= 64'h0000_0000_0000_0000;
      lineTxMask <= 8'h00;
      lineTxValid <= 1'b0;
      lineTxStart <= 1'b0;
      lineTxEnd <= 1'b0;
      txAcceptReady <= 1'b0;
    end else if (syncReset) begin
      lineTxWord <= 64'h0000_0000_0000_0000;
      lineTxMask <= 8'h00;
      lineTxValid <= 1'b0;
      lineTxStart <= 1'b0;
      lineTxEnd <= 1'b0;
      txAcceptReady <= 1'b0;
    end else begin
      lineTxWord <= next_lineTxWord;
      lineTxMask <= next_lineTxMask;
      lineTxValid <= next_lineTxValid;
      lineTxStart <= next_lineTxStart;
      lineTxEnd <= next_lineTxEnd;
      // The word already allowed in still counts, so the next allowed one always fits
      txAcceptReady <= ((txNextCount + {2'b00, txAcceptReady}) < 3'd2);
    end
  end

  // ************************************************************
  // Receive checker
  // ************************************************************
  logic [14:0] rxBytes;
  logic [31:0] rxCrc;
  logic rxLong;
  logic rxLost;
  logic rxOwe;
  logic [3:0] rN;
  logic [14:0] rTotal;
  logic [31:0] rCrc;
  logic rLong;
  logic rGood;
  logic rPushFail;
  logic oweSlot;
  logic [7:0] rMaskOut;

  assign rN = mus_byte_count(lineRxMask);
  assign rTotal = (lineRxStart ? 15'h0000 : rxBytes) + {11'h000, rN};
  assign rCrc = mus_crc_step(lineRxStart ? CRC_INIT : rxCrc, lineRxWord, rN);
  assign rLong = (!lineRxStart && rxLong)
                 || (rTotal > RX_PAYLOAD_LIMIT + HDR_FCS_BYTES);
  assign rGood = (rCrc == CRC_RESIDUE) && (rTotal >= MIN_FRAME) && !rLong
                 && !(rxLost && !lineRxStart);
  assign rPushFail = lineRxValid && !rxIn.ready;
  assign oweSlot = rxOwe && !lineRxValid;
  // A bad frame ends on an empty word so the user can drop it
  assign rMaskOut = (lineRxEnd && !rGood) ? 8'h00 : lineRxMask;

  assign rxIn.valid = lineRxValid || oweSlot;
  assign rxIn.data = oweSlot ? {1'b0, 1'b0, 1'b1, 8'h00, 64'h0000_0000_0000_0000}
                     : {lineRxEnd && rGood, lineRxStart, lineRxEnd, rMaskOut, lineRxWord};
  assign rxOut.ready = rxSinkReady;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBytes <= 15'h0000;
      rxCrc <= CRC_INIT;
      rxLong <= 1'b0;
      rxLost <= 1'b0;
      rxOwe <= 1'b0;
    end else if (syncReset) begin
      rxBytes <= 15'h0000;
      rxCrc <= CRC_INIT;
      rxLong <= 1'b0;
      rxLost <= 1'b0;
      rxOwe <= 1'b0;
    end else begin
      if (lineRxValid) begin
        rxBytes <= rTotal;
        rxCrc <= rCrc;
        rxLong <= rLong;
        rxLost <= (rxLost && !lineRxStart) || rPushFail;
      end
      // A lost end word is replaced later so every frame still ends
      rxOwe <= (rxOwe && !(oweSlot && rxIn.ready)) || (rPushFail && lineRxEnd);
    end
  end

  // ************************************************************
  // Receive user outputs
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxUserWord <= 64'h0000_0000_0000_0000;
      rxByteMask <= 8'h00;
      rxFirstWordPulse <= 1'b0;
      rxLastWordPulse <= 1'b0;
      rxFrameGood <= 1'b0;
    end else if (syncReset || !(rxSinkReady && rxOut.valid)) begin
      rxUserWord <= 64'h0000_0000_0000_0000;
      rxByteMask <= 8'h00;
      rxFirstWordPulse <= 1'b0;
      rxLastWordPulse <= 1'b0;
      rxFrameGood <= 1'b0;
    end else begin
      rxUserWord <= rxOut.data[E_WORD_LSB +: DATA_W];
      rxByteMask <= rxOut.data[E_MASK_LSB +: MASK_W];
      rxFirstWordPulse <= rxOut.data[E_SOF];
      rxLastWordPulse <= rxOut.data[E_EOF];
      rxFrameGood <= rxOut.data[E_GOOD];
    end
  end

  // ************************************************************
  // Management address
  // ************************************************************
  // No timers here; core_clk at USER_CLK_MHZ stays the only time base
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyMgmtDeviceAddr <= 5'h00;
    end else begin
      phyMgmtDeviceAddr <= PHY_MGMT_DEVICE_ADDR;
    end
  end
endmodule

// ==== test/mus_user_stream_monitor.sv ====
// Concurrent port checks of the user stream block
`timescale 1ns/1ps
module mus_user_stream_monitor
  import mus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic syncReset,
  input wire logic rxSinkReady,
  input wire logic txAcceptReady,
  input wire logic [mus_pkg::MASK_W-1:0] rxByteMask,
  input wire logic rxFirstWordPulse,
  input wire logic rxLastWordPulse,
  input wire logic rxFrameGood,
  input wire logic [mus_pkg::DATA_W-1:0] lineTxWord,
  input wire logic [mus_pkg::MASK_W-1:0] lineTxMask,
  input wire logic lineTxValid,
  input wire logic lineTxStart,
  input wire logic [4:0] phyMgmtDeviceAddr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic legalMask(logic [7:0] m);
    return m inside {8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF};
  endfunction

  sequence s_noRx;
    rxByteMask == 8'h00 && !rxFirstWordPulse && !rxLastWordPulse;
  endsequence
  sequence s_quiet;
    s_noRx and (!txAcceptReady && !rxFrameGood && !lineTxValid);
  endsequence

  // ********************
  // Assertions
  // ********************
  chk_rx_mask_legal:
    assert property (legalMask(rxByteMask)) else $error("rx mask not contiguous");
  chk_tx_mask_legal:
    assert property (lineTxValid |-> legalMask(lineTxMask)) else $error("line mask bad");
  chk_rx_wait_ready:
    assert property (!rxSinkReady |=> s_noRx) else $error("rx word without ready");
  chk_sof_one_cycle:
    assert property (rxFirstWordPulse |=> !rxFirstWordPulse) else $error("sof too long");
  chk_eof_one_cycle:
    assert property ($rose(rxLastWordPulse) |=> $fell(rxLastWordPulse)) else $error("eof long");
  chk_good_at_end:
    assert property (rxFrameGood |-> rxLastWordPulse && rxByteMask != 8'h00)
      else $error("good flag off end word");
  chk_tx_preamble_word:
    assert property (lineTxStart |-> lineTxValid && lineTxWord == PREAMBLE_WORD
      && lineTxMask == 8'hFF) else $error("bad preamble word");
  chk_sreset_quiet:
    assert property (syncReset |=> s_quiet) else $error("outputs live after sync reset");
  chk_ready_returns:
    assert property ($fell(syncReset) |-> ##[0:3] txAcceptReady) else $error("ready stuck");
  chk_phy_mgmt_addr:
    assert property (1'b1 |=> phyMgmtDeviceAddr == PHY_MGMT_DEVICE_ADDR)
      else $error("phy address wrong");
endmodule

bind mus_user_stream mus_user_stream_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n),
  .syncReset(syncReset), .rxSinkReady(rxSinkReady), .txAcceptReady(txAcceptReady),
  .rxByteMask(rxByteMask), .rxFirstWordPulse(rxFirstWordPulse),
  .rxLastWordPulse(rxLastWordPulse), .rxFrameGood(rxFrameGood), .lineTxWord(lineTxWord),
  .lineTxMask(lineTxMask), .lineTxValid(lineTxValid), .lineTxStart(lineTxStart),
  .phyMgmtDeviceAddr(phyMgmtDeviceAddr));

// ==== test/mus_user_app.sv ====
// Behavioural user application on the receive side of the block
`timescale 1ns/1ps
module mus_user_app (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slowSink,
  input wire logic rxLastWordPulse,
  input wire logic rxFrameGood,
  output logic rxSinkReady,
  output int goodFrames
);
  // Slow mode opens a slot every other cycle so the block must hold words back
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSinkReady <= 1'b0;
      goodFrames <= 0;
    end else begin
      rxSinkReady <= #1 slowSink ? !rxSinkReady : 1'b1;
      // An end word without the good flag means the frame is thrown away
      if (rxLastWordPulse === 1'b1 && rxFrameGood === 1'b1) begin
        goodFrames <= goodFrames + 1;
      end
    end
  end
endmodule

// ==== test/mus_user_stream_tb.sv ====
// Self-checking bench for the user stream block
`timescale 1ns/1ps
module mus_user_stream_tb;
  import mus_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, syncReset = 1'b0, slowSink = 1'b0;
  logic padEnable = 1'b0, crcEnable = 1'b0, txFirstWordPulse = 1'b0, txLastWordPulse = 1'b0;
  logic lineRxValid = 1'b0, lineRxStart = 1'b0, lineRxEnd = 1'b0;
  logic [63:0] txUserWord = 64'h0, lineRxWord = 64'h0, rxUserWord, lineTxWord;
  logic [7:0] txByteMask = 8'h00, lineRxMask = 8'h00, rxByteMask, lineTxMask;
  logic txAcceptReady, rxSinkReady, rxFirstWordPulse, rxLastWordPulse, rxFrameGood;
  logic lineTxValid, lineTxStart, lineTxEnd;
  logic [4:0] phyMgmtDeviceAddr;
  int goodFrames, miscompares = 0, total_checks = 0, cycles = 0;
  logic [63:0] txW[$], rxW[$];
  logic [7:0] txM[$], rxM[$], expB[$], gotB[$];
  logic [2:0] txF[$], rxF[$];

  mus_user_stream i_dut (.core_clk(core_clk), .rst_n(rst_n), .syncReset(syncReset),
    .padEnable(padEnable), .crcEnable(crcEnable), .txUserWord(txUserWord),
    .txByteMask(txByteMask), .txFirstWordPulse(txFirstWordPulse),
    .txLastWordPulse(txLastWordPulse), .txAcceptReady(txAcceptReady),
    .rxUserWord(rxUserWord), .rxByteMask(rxByteMask), .rxFirstWordPulse(rxFirstWordPulse),
    .rxLastWordPulse(rxLastWordPulse), .rxFrameGood(rxFrameGood), .rxSinkReady(rxSinkReady),
    .lineTxWord(lineTxWord), .lineTxMask(lineTxMask), .lineTxValid(lineTxValid),
    .lineTxStart(lineTxStart), .lineTxEnd(lineTxEnd), .lineRxWord(lineRxWord),
    .lineRxMask(lineRxMask), .lineRxValid(lineRxValid), .lineRxStart(lineRxStart),
    .lineRxEnd(lineRxEnd), .phyMgmtDeviceAddr(phyMgmtDeviceAddr));
  mus_user_app i_app (.core_clk(core_clk), .rst_n(rst_n), .slowSink(slowSink),
    .rxLastWordPulse(rxLastWordPulse), .rxFrameGood(rxFrameGood),
    .rxSinkReady(rxSinkReady), .goodFrames(goodFrames));

  always #5 core_clk = ~core_clk;

  // ********************
  // Capture and helpers
  // ********************
  always @(posedge core_clk) begin
    cycles++;
    if (lineTxValid === 1'b1) begin
      txW.push_back(lineTxWord);
      txM.push_back(lineTxMask);
      txF.push_back({1'b0, lineTxStart, lineTxEnd});
    end
    if (rxByteMask !== 8'h00 || rxLastWordPulse === 1'b1) begin
      rxW.push_back(rxUserWord);
      rxM.push_back(rxByteMask);
      rxF.push_back({rxFirstWordPulse, rxLastWordPulse, rxFrameGood});
    end
    // Whole run needs well under a thousand cycles
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] crcB(input logic [31:0] c, input logic [7:0] b);
    for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction

  function automatic logic [63:0] wordAt(input int w);
    logic [63:0] e;
    for (int j = 0; j < 8; j++) e[8*j+:8] = (8*w+j < expB.size()) ? expB[8*w+j] : 8'h00;
    return e;
  endfunction

  task automatic addFcs();
    logic [31:0] c;
    c = CRC_INIT;
    foreach (expB[i]) c = crcB(c, expB[i]);
    for (int j = 0; j < 4; j++) expB.push_back(~c[8*j+:8]);
  endtask

  // Idle lanes carry a moving pattern so stale data never looks valid
  task automatic idleTx();
    txByteMask = 8'h00;
    txFirstWordPulse = 1'b0;
    txLastWordPulse = 1'b0;
    txUserWord = ~txUserWord;
  endtask

  task automatic sendTx(input logic [63:0] w, input logic [7:0] m, input logic s, input logic e);
    @(posedge core_clk);
    while (txAcceptReady !== 1'b1) begin
      #1 idleTx();
      @(posedge core_clk);
    end
    #1 txUserWord = w;
    txByteMask = m;
    txFirstWordPulse = s;
    txLastWordPulse = e;
  endtask

  task automatic runTx(input logic pad, input logic crc, input int n);
    int r;
    padEnable = pad;
    crcEnable = crc;
    expB.delete();
    txW.delete();
    txM.delete();
    txF.delete();
    gotB.delete();
    for (int i = 0; i < n; i++) expB.push_back(8'(i + 1));
    for (int k = 0; k < n; k += 8) begin
      r = n - k;
      sendTx(wordAt(k / 8), (r >= 8) ? 8'hFF : 8'((1 << r) - 1), k == 0, r <= 8);
    end
    @(posedge core_clk);
    #1 idleTx();
    repeat (24) @(posedge core_clk);
    #1;
    if (pad && crc) while (expB.size() < 60) expB.push_back(8'h00);
    if (crc) addFcs();
    for (int i = 1; i < txW.size(); i++) begin
      for (int j = 0; j < 8; j++) if (txM[i][j]) gotB.push_back(txW[i][8*j+:8]);
    end
    chkv(txW[0], PREAMBLE_WORD);
    chkv(64'(txF[0]), 64'h2);
    chkv(64'(txF[txF.size()-1]), 64'h1);
    chkv(64'(gotB.size()), 64'(expB.size()));
    foreach (expB[i]) chkv(64'(gotB[i]), 64'(expB[i]));
  endtask

  task automatic sendRx(input logic bad, input int gap);
    expB.delete();
    rxW.delete();
    rxM.delete();
    rxF.delete();
    for (int i = 0; i < 60; i++) expB.push_back(8'(i + 1));
    addFcs();
    for (int w = 0; w < 8; w++) begin
      lineRxWord = wordAt(w) ^ 64'(bad && w == 1);
      lineRxMask = 8'hFF;
      lineRxValid = 1'b1;
      lineRxStart = (w == 0);
      lineRxEnd = (w == 7);
      @(posedge core_clk);
      #1;
      // Back to back words keep valid high; a gap idles the line
      if (gap > 0 || w == 7) begin
        lineRxValid = 1'b0;
        lineRxStart = 1'b0;
        lineRxEnd = 1'b0;
        lineRxMask = 8'h00;
        lineRxWord = ~lineRxWord;
        repeat (gap) @(posedge core_clk);
        if (gap > 0) #1;
      end
    end
    repeat (12) @(posedge core_clk);
    #1;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic testTxPad();
    runTx(1'b1, 1'b1, 8);
    $display("Test tx pad done");
  endtask

  task automatic testTxCrc();
    runTx(1'b0, 1'b1, 12);
    runTx(1'b0, 1'b1, 22);
    $display("Test tx crc done");
  endtask

  task automatic testTxRaw();
    runTx(1'b1, 1'b0, 12);
    $display("Test tx raw done");
  endtask

  task automatic testRxGood(input logic slow);
    int g;
    g = goodFrames;
    slowSink = slow;
    sendRx(1'b0, slow ? 1 : 0);
    slowSink = 1'b0;
    chkv(64'(rxW.size()), 64'd8);
    for (int w = 0; w < 8; w++) begin
      chkv(rxW[w], wordAt(w));
      chkv(64'(rxM[w]), 64'hFF);
    end
    chkv(64'(rxF[0]), 64'h4);
    chkv(64'(rxF[7]), 64'h3);
    chkv(64'(goodFrames), 64'(g + 1));
    $display("Test rx good done");
  endtask

  // A corrupted word with a fast sink, or a slow sink against back to back words overflowing the buffer, loses the frame
  task automatic testRxBad(input logic slow);
    int g;
    g = goodFrames;
    slowSink = slow;
    sendRx(!slow, 0);
    slowSink = 1'b0;
    chkv(64'(rxF[0]), 64'h4);
    chkv(64'(rxF[rxF.size()-1]), 64'h2);
    chkv(64'(rxM[rxM.size()-1]), 64'h0);
    chkv(64'(goodFrames), 64'(g));
    $display("Test rx bad done");
  endtask

  task automatic testSyncReset();
    sendTx(64'h1111_2222_3333_4444, 8'hFF, 1'b1, 1'b0);
    @(posedge core_clk);
    #1 idleTx();
    syncReset = 1'b1;
    @(posedge core_clk);
    #1 syncReset = 1'b0;
    chkv(64'(txAcceptReady), 64'h0);
    chkv(64'(lineTxValid), 64'h0);
    runTx(1'b0, 1'b0, 12);
    $display("Test sync reset done");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    testTxPad();
    testTxCrc();
    testTxRaw();
    testRxGood(1'b0);
    testRxGood(1'b1);
    testRxBad(1'b0);
    testRxBad(1'b1);
    testSyncReset();
    end_of_test();
  end
endmodule
